/* src/sptc_pkg.sv */
`default_nettype none
package sptc_pkg;
    // register addresses (byte addresses of the register space)
    localparam logic [9:0] SPTC_ADDR_PLL_STATUS = 10'h281;
    localparam logic [9:0] SPTC_ADDR_REF_DIVIDER = 10'h289;
    localparam logic [9:0] SPTC_ADDR_TERM_START_A = 10'h2a7;
    localparam logic [9:0] SPTC_ADDR_TERM_OVERRIDE_A = 10'h2a8;
    localparam logic [9:0] SPTC_ADDR_TERM_READBACK_A = 10'h2ac;
    localparam int SPTC_ADDR_W = 10;
    localparam int SPTC_DATA_W = 8;
    // field positions
    localparam int SPTC_LOCK_BIT = 0;
    localparam int SPTC_CP_VALID_BIT = 3;
    localparam int SPTC_CP_LOW_BIT = 4;
    localparam int SPTC_CP_HIGH_BIT = 5;
    localparam int SPTC_TRIGGER_BIT = 0;
    localparam int SPTC_OVR_EN_BIT = 4;
    localparam int SPTC_OVR_CODE_LSB = 1;
    localparam int SPTC_OVR_CODE_MSB = 3;
    // reset values
    localparam logic [7:0] SPTC_RESET_VALUE = 8'h00;
    // divider select encodings
    localparam logic [1:0] SPTC_DIV_BY_4 = 2'h0;
    localparam logic [1:0] SPTC_DIV_BY_2 = 2'h1;
    localparam logic [1:0] SPTC_DIV_BY_1 = 2'h2;
    localparam logic [2:0] SPTC_RATIO_4 = 3'h4;
    localparam logic [2:0] SPTC_RATIO_2 = 3'h2;
    localparam logic [2:0] SPTC_RATIO_1 = 3'h1;
    // pfd input window, MHz, kept by software
    localparam int SPTC_PFD_MIN_MHZ = 35;
    localparam int SPTC_PFD_MAX_MHZ = 80;
endpackage
`default_nettype wire

/* src/sptc_regs.sv */
`default_nettype none
// Contract
// - cp valid bit reads calibration done-valid
// - bit 0 status shows synthesizer lock
// - divider field divides reference before pfd
// - 00 div4, 01 div2, 10 div1
// - trigger bit rising edge starts calibration
// - override register rw, reset zero
// - bit4 clear selects calibrated termination
// - override forces any 3-bit code
// - forced code from bits 3:1
// - readback shows 4-bit code, upper zero
module sptc_regs
    import sptc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register port, same clock domain
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [sptc_pkg::SPTC_ADDR_W-1:0] reg_addr,
    input wire logic [sptc_pkg::SPTC_DATA_W-1:0] reg_wdata,
    output logic [sptc_pkg::SPTC_DATA_W-1:0] reg_rdata,
    // analog status, asynchronous to clock
    input wire logic pll_locked_in,
    input wire logic cp_cal_valid_in,
    input wire logic cp_over_low_in,
    input wire logic cp_over_high_in,
    input wire logic [3:0] term_cal_code_in,
    // reference path
    input wire logic ref_clk_en,
    output logic pfd_ref_en,
    output logic [1:0] ref_div_select,
    // termination control
    output logic term_cal_start,
    output logic term_override_en,
    output logic [2:0] term_forced_code,
    output logic [3:0] term_code_readback_a
);
    import sptc_pkg::*;

    // field slicing below assumes eight-bit registers and ten address bits
    if (SPTC_DATA_W != 8 || SPTC_ADDR_W != 10) begin : g_width_check
        $error("sptc_regs needs 8-bit data and 10-bit addresses");
    end

    logic [7:0] ref_divider;
    logic [7:0] next_ref_divider;
    logic [7:0] term_start;
    logic [7:0] next_term_start;
    logic [7:0] term_override;
    logic [7:0] next_term_override;
    logic [7:0] next_rdata;
    logic [1:0] div_cnt;
    logic [1:0] next_div_cnt;
    logic [2:0] ratio;
    logic next_pfd_ref_en;
    logic next_cal_start;
    logic trig_prev;
    logic next_trig_prev;
    // two-flop synchronisers for the analog status levels
    logic [7:0] sync_a;
    logic [7:0] sync_b;
    logic [7:0] stat_raw;
    // the code is a word from another domain: only a value seen twice in a row
    // is taken, so a capture that straddles a code change never reaches software
    logic [3:0] code_prev;
    logic [3:0] code_hold;
    logic [3:0] next_code_hold;

    wire logic serial_lock_flag = sync_b[0];
    wire logic pump_cal_valid_flag = sync_b[1];

    assign stat_raw = {term_cal_code_in, cp_over_high_in, cp_over_low_in,
                       cp_cal_valid_in, pll_locked_in};

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sync_a <= SPTC_RESET_VALUE;
            sync_b <= SPTC_RESET_VALUE;
        end else begin
            sync_a <= stat_raw;
            sync_b <= sync_a;
        end
    end

    // register writes
    always_comb begin
        next_ref_divider = ref_divider;
        next_term_start = term_start;
        next_term_override = term_override;
        if (reg_wr) begin
            case (reg_addr)
                SPTC_ADDR_REF_DIVIDER: begin
                    next_ref_divider = {6'h00, reg_wdata[1:0]};
                end
                SPTC_ADDR_TERM_START_A: begin
                    next_term_start = {7'h00, reg_wdata[SPTC_TRIGGER_BIT]};
                end
                SPTC_ADDR_TERM_OVERRIDE_A: begin
                    next_term_override = reg_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // read mux; unmapped and reserved bits read zero, except override bits 7:5 and 0, which read back as written
    always_comb begin
        next_rdata = reg_rdata;
        if (reg_rd) begin
            case (reg_addr)
                SPTC_ADDR_PLL_STATUS: begin
                    next_rdata = 8'h00;
                    next_rdata[SPTC_LOCK_BIT] = serial_lock_flag;
                    next_rdata[SPTC_CP_VALID_BIT] = pump_cal_valid_flag;
                    next_rdata[SPTC_CP_LOW_BIT] = sync_b[2];
                    next_rdata[SPTC_CP_HIGH_BIT] = sync_b[3];
                end
                SPTC_ADDR_REF_DIVIDER: next_rdata = ref_divider;
                SPTC_ADDR_TERM_START_A: next_rdata = term_start;
                SPTC_ADDR_TERM_OVERRIDE_A: next_rdata = term_override;
                SPTC_ADDR_TERM_READBACK_A: next_rdata = {4'h0, code_hold};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // trigger edge: launch happens on the register's 0 to 1 change only,
    // so holding it at 1 never relaunches
    always_comb begin
        next_trig_prev = term_start[SPTC_TRIGGER_BIT];
        next_cal_start = (term_start[SPTC_TRIGGER_BIT] && !trig_prev);
    end

    // reference divider, clock-enable form of the pfd reference
    always_comb begin
        case (ref_divider[1:0])
            SPTC_DIV_BY_4: ratio = SPTC_RATIO_4;
            SPTC_DIV_BY_2: ratio = SPTC_RATIO_2;
            SPTC_DIV_BY_1: ratio = SPTC_RATIO_1;
            default: ratio = SPTC_RATIO_1; // undefined code 11 treated as div1
        endcase
        next_div_cnt = div_cnt;
        next_pfd_ref_en = 1'b0;
        if (ref_clk_en) begin
            if ({1'b0, div_cnt} >= ratio - 3'h1) begin
                next_div_cnt = 2'h0;
                next_pfd_ref_en = 1'b1;
            end else begin
                next_div_cnt = div_cnt + 2'h1;
            end
        end
    end

    // calibration code filter
    always_comb begin
        next_code_hold = code_hold;
        if (sync_b[7:4] == code_prev) begin
            next_code_hold = code_prev;
        end
    end

    // register bank
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ref_divider <= SPTC_RESET_VALUE;
            term_start <= SPTC_RESET_VALUE;
            term_override <= SPTC_RESET_VALUE;
        end else begin
            ref_divider <= next_ref_divider;
            term_start <= next_term_start;
            term_override <= next_term_override;
        end
    end

    // read data stands until the next read
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reg_rdata <= SPTC_RESET_VALUE;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // trigger edge detector and start pulse
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            trig_prev <= 1'b0;
            term_cal_start <= 1'b0;
        end else begin
            trig_prev <= next_trig_prev;
            term_cal_start <= next_cal_start;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            div_cnt <= 2'h0;
            pfd_ref_en <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            pfd_ref_en <= next_pfd_ref_en;
        end
    end

    // the held code is what the pin and the readback show
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            code_prev <= SPTC_RESET_VALUE[3:0];
            code_hold <= SPTC_RESET_VALUE[3:0];
        end else begin
            code_prev <= sync_b[7:4];
            code_hold <= next_code_hold;
        end
    end

    assign ref_div_select = ref_divider[1:0];
    assign term_override_en = term_override[SPTC_OVR_EN_BIT];
    // bit 0 of the override is ignored by the termination path
    assign term_forced_code = term_override[SPTC_OVR_CODE_MSB:SPTC_OVR_CODE_LSB];
    assign term_code_readback_a = code_hold;
endmodule
`default_nettype wire

/* verification/sptc_regs_sva.sv */
`default_nettype none
module sptc_regs_sva
    import sptc_pkg::*;
(
    // clock, reset and register port
    input wire logic clock,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [9:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    // reference path and termination
    input wire logic ref_clk_en,
    input wire logic pfd_ref_en,
    input wire logic [1:0] ref_div_select,
    input wire logic term_cal_start,
    input wire logic term_override_en,
    input wire logic [2:0] term_forced_code
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence rd_at(logic [9:0] a);
        reg_rd && reg_addr == a;
    endsequence
    sequence start_pulse;
        term_cal_start ##1 !term_cal_start;
    endsequence
    a_status_rsvd_zero: assert property (rd_at(SPTC_ADDR_PLL_STATUS) |=>
        reg_rdata[7:6] == 2'h0 && reg_rdata[2:1] == 2'h0) else $error("status reserved set");
    a_div_read_back: assert property (rd_at(SPTC_ADDR_REF_DIVIDER) |=>
        reg_rdata == {6'h00, $past(ref_div_select)}) else $error("divider readback wrong");
    a_ovr_read_back: assert property (rd_at(SPTC_ADDR_TERM_OVERRIDE_A) |=>
        reg_rdata[4:1] == {$past(term_override_en), $past(term_forced_code)})
        else $error("override readback wrong");
    a_readback_upper_zero: assert property (rd_at(SPTC_ADDR_TERM_READBACK_A) |=>
        reg_rdata[7:4] == 4'h0) else $error("readback upper bits set");
    a_trig_rsvd_zero: assert property (rd_at(SPTC_ADDR_TERM_START_A) |=>
        reg_rdata[7:1] == 7'h00) else $error("trigger reserved set");
    a_start_single: assert property ($rose(term_cal_start) |-> start_pulse)
        else $error("start pulse too long");
    a_start_cause: assert property ($rose(term_cal_start) |->
        $past(reg_wr, 2) && $past(reg_addr, 2) == SPTC_ADDR_TERM_START_A)
        else $error("start without write");
    a_pfd_div_one: assert property (ref_clk_en && ref_div_select == SPTC_DIV_BY_1 &&
        $past(ref_div_select) == SPTC_DIV_BY_1 |=> pfd_ref_en) else $error("div1 missed");
    // a select change may give one short period, so the gap is only owed while it holds
    a_pfd_div_four: assert property (pfd_ref_en && ref_div_select == SPTC_DIV_BY_4 |=>
        (!pfd_ref_en || ref_div_select != SPTC_DIV_BY_4) [*3]) else $error("div4 too fast");
endmodule
bind sptc_regs sptc_regs_sva chk_i (.clock, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_rdata,
    .ref_clk_en, .pfd_ref_en, .ref_div_select, .term_cal_start, .term_override_en,
    .term_forced_code);
`default_nettype wire

/* verification/tb_top.sv */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import sptc_pkg::*;
    logic clock = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, ref_clk_en = 1'b1;
    logic pll_locked_in = 1'b0, cp_cal_valid_in = 1'b0;
    logic cp_over_low_in = 1'b0, cp_over_high_in = 1'b0;
    logic gap = 1'b0;
    logic [9:0] reg_addr = '0;
    logic [7:0] reg_wdata = '0, reg_rdata;
    logic [3:0] term_cal_code_in = '0, term_code_readback_a;
    logic pfd_ref_en, term_cal_start, term_override_en;
    logic [1:0] ref_div_select;
    logic [2:0] term_forced_code;
    int fail_count = 0, cmp_count = 0, pcnt = 0, scnt = 0;
    always #25 clock = ~clock;
    sptc_regs dut (.clock, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .pll_locked_in, .cp_cal_valid_in, .cp_over_low_in, .cp_over_high_in,
        .term_cal_code_in, .ref_clk_en, .pfd_ref_en, .ref_div_select, .term_cal_start,
        .term_override_en, .term_forced_code, .term_code_readback_a);
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // each access lets one edge pass first, so back-to-back calls never
    // lower and raise a strobe in the same time step
    task automatic wr(logic [9:0] a, logic [7:0] d);
        @(posedge clock) #1;
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clock) #1;
        reg_wr = 0;
    endtask
    task automatic rd(logic [9:0] a, logic [7:0] e, string n);
        @(posedge clock) #1;
        reg_rd = 1;
        reg_addr = a;
        @(posedge clock) #1;
        reg_rd = 0;
        chk(n, e, reg_rdata);
    endtask
    // with gap set the reference tick comes every other cycle
    task automatic cyc(int n);
        repeat (n) begin
            @(posedge clock) #1;
            pcnt += pfd_ref_en;
            scnt += term_cal_start;
            if (gap) begin
                ref_clk_en = !ref_clk_en;
            end
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // no handshake waits here, so a plain time limit guards the run
    initial begin
        #50000;
        fail_count++;
        tally_and_finish;
    end
    initial begin
        repeat (12) @(posedge clock);
        #1 rst_n = 1;
        rd(SPTC_ADDR_TERM_OVERRIDE_A, 8'h00, "override");
        rd(SPTC_ADDR_PLL_STATUS, 8'h00, "status idle");
        rd(10'h3ff, 8'h00, "unmapped");
        pll_locked_in = 1;
        cp_cal_valid_in = 1;
        term_cal_code_in = 4'ha;
        cyc(3);
        wr(SPTC_ADDR_PLL_STATUS, 8'hff);
        wr(SPTC_ADDR_TERM_READBACK_A, 8'hff);
        rd(SPTC_ADDR_PLL_STATUS, 8'h09, "status");
        rd(SPTC_ADDR_TERM_READBACK_A, 8'h0a, "readback");
        chk("code pin", 8'h0a, {4'h0, term_code_readback_a});
        pll_locked_in = 0;
        cp_over_low_in = 1;
        cp_over_high_in = 1;
        cyc(3);
        rd(SPTC_ADDR_PLL_STATUS, 8'h38, "status range");
        // code 11 is taken as divide by one
        for (int g = 0; g < 2; g++) begin
            gap = g[0];
            for (int s = 0; s < 4; s++) begin
                wr(SPTC_ADDR_REF_DIVIDER, 8'hfc | 8'(s));
                cyc(4);
                pcnt = 0;
                cyc(12 << g);
                chk("pfd", (s == 0) ? 8'd3 : (s == 1) ? 8'd6 : 8'd12, 8'(pcnt));
                chk("select", 8'(s), {6'h00, ref_div_select});
                rd(SPTC_ADDR_REF_DIVIDER, 8'(s), "divider");
            end
        end
        gap = 0;
        ref_clk_en = 1;
        wr(SPTC_ADDR_TERM_OVERRIDE_A, 8'h1b);
        chk("forced", 8'h0d, {4'h0, term_override_en, term_forced_code});
        rd(SPTC_ADDR_TERM_OVERRIDE_A, 8'h1b, "override");
        for (int c = 0; c < 8; c++) begin
            wr(SPTC_ADDR_TERM_OVERRIDE_A, 8'h10 | 8'(c << 1) | 8'(c % 2));
            chk("forced", 8'h08 | 8'(c), {4'h0, term_override_en, term_forced_code});
        end
        wr(SPTC_ADDR_TERM_OVERRIDE_A, 8'h0a);
        chk("auto", 8'h05, {4'h0, term_override_en, term_forced_code});
        // mid-run reset: the written registers come back at zero
        rst_n = 0;
        cyc(2);
        rst_n = 1;
        rd(SPTC_ADDR_TERM_OVERRIDE_A, 8'h00, "override reset");
        rd(SPTC_ADDR_REF_DIVIDER, 8'h00, "divider reset");
        chk("auto reset", 8'h00, {4'h0, term_override_en, term_forced_code});
        for (int i = 0; i < 4; i++) begin
            scnt = 0;
            wr(SPTC_ADDR_TERM_START_A, 8'(i != 2));
            cyc(4);
            chk("start", 8'(i == 0 || i == 3), 8'(scnt));
        end
        rd(SPTC_ADDR_TERM_START_A, 8'h01, "trigger");
        tally_and_finish;
    end
endmodule
`default_nettype wire
